// ---- design/adc_serial_config_decoder.sv ----
// serial command decoder, configuration registers and result output of the converter
`timescale 1ns/1ps
`include "adc_cfg_consts.svh"
`default_nettype none
module adc_serial_config_decoder (
    // system clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial link pins and the convert-start pin
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    input wire logic convert_start_pin,
    // configuration outputs
    output adc_cfg_pkg::setup_t setup_cfg,
    output logic [7:0] unipolar_pair_select,
    output logic [7:0] bipolar_pair_select,
    output adc_cfg_pkg::avg_t averaging_cfg,
    output logic convert_start_pin_active,
    output logic top_channel_shared_pin_analog,
    output logic second_channel_shared_pin_analog,
    output logic reference_internal,
    output logic reference_always_on,
    output logic reference_wake_needed,
    output logic sclk_conversion_clock,
    output logic [5:0] conversions_per_result,
    output logic [4:0] repeat_results,
    // command outputs
    output adc_cfg_pkg::conv_cmd_t conv_cmd,
    output logic conv_cmd_valid,
    output logic conversion_start,
    output logic fifo_clear,
    // result formatting
    input wire logic conv_valid,
    input wire logic [11:0] conv_code,
    input wire logic [3:0] conv_channel,
    input wire logic temp_valid,
    input wire logic [11:0] temp_high_code,
    input wire logic [11:0] temp_low_code,
    output logic [15:0] result_word,
    output logic result_taken
);
    import adc_cfg_pkg::*;

    // ----------------------------------------
    // helper functions
    // ----------------------------------------
    // pair bit for a channel: bit 7 covers channels 0 and 1
    function automatic logic [2:0] pair_bit(input logic [3:0] ch);
        pair_bit = `PAIR_TOP - ch[3:1];
    endfunction

    // ----------------------------------------
    // link domain: shift in on the rising edge
    // ----------------------------------------
    logic [2:0] in_count;
    logic [6:0] in_shift;
    logic [7:0] rx_byte;
    logic rx_toggle;

    // frame counter ends with chip select, since sclk stops between frames
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            in_count <= 3'h0;
            in_shift <= 7'h00;
        end else begin
            in_count <= in_count + 3'h1;
            in_shift <= {in_shift[5:0], din};
        end
    end

    // completed byte held stable for the system domain until the next byte
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_byte <= `BYTE_RESET;
            rx_toggle <= 1'b0;
        end else if (!cs_n && in_count == `BIT_LAST) begin
            rx_byte <= {in_shift, din};
            rx_toggle <= ~rx_toggle;
        end
    end

    // ----------------------------------------
    // link domain: shift out on the falling edge
    // ----------------------------------------
    logic [3:0] out_count;
    logic [15:0] out_word;

    // the word is quasi-static: result_word only changes outside frames
    assign out_word = result_word;

    // bit 15 is always zero, so the idle level of dout already serves as the first bit
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            out_count <= 4'h0;
            dout <= 1'b0;
        end else begin
            out_count <= out_count + 4'h1;
            dout <= out_word[`RESULT_MSB_CODE - (out_count + 4'h1)];
        end
    end

    // ----------------------------------------
    // crossings into the system domain
    // ----------------------------------------
    logic tog_s1, tog_s2, tog_s3;
    logic cs_s1, cs_s2;
    logic cv_s1, cv_s2, cv_s3;
    logic byte_event;
    logic pin_rise;

    // two stages settle the toggle; the third only finds its edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
        end else begin
            tog_s1 <= rx_toggle;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
        end
    end

    // chip select idles high, so its stages reset high and no frame is seen at reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
        end else begin
            cs_s1 <= cs_n;
            cs_s2 <= cs_s1;
        end
    end

    // pin stages reset high: a pin idling low then shows a fall, never a false start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cv_s1 <= 1'b1;
            cv_s2 <= 1'b1;
            cv_s3 <= 1'b1;
        end else begin
            cv_s1 <= convert_start_pin;
            cv_s2 <= cv_s1;
            cv_s3 <= cv_s2;
        end
    end

    assign byte_event = tog_s2 ^ tog_s3;
    assign pin_rise = cv_s2 & ~cv_s3;

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    decode_state_t state;
    logic is_conv, is_setup, is_avg, is_reset, full_reset;

    // leading one picks the register
    // the classes exclude each other, so only a full reset byte writes more than one register
    assign is_conv = rx_byte[`CMD_CONV_BIT];
    assign is_setup = !is_conv && rx_byte[`CMD_SETUP_BIT];
    assign is_avg = rx_byte[7:6] == 2'h0 && rx_byte[`CMD_AVG_BIT];
    assign is_reset = rx_byte[7:5] == 3'h0 && rx_byte[`CMD_RESET_BIT];
    assign full_reset = byte_event && state == ST_COMMAND && is_reset && !rx_byte[`RESET_FIFO_ONLY_BIT];

    // a data byte is only expected inside the same frame as its setup byte
    // a cut frame drops the expectation, so a stray byte never lands in a pair register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_COMMAND;
        end else begin
            case (state)
                ST_COMMAND: begin
                    if (byte_event && is_setup && rx_byte[`SETUP_PAIR_HI:`SETUP_PAIR_LO] == `PAIR_UNI) begin
                        state <= ST_EXPECT_UNI;
                    end else if (byte_event && is_setup && rx_byte[`SETUP_PAIR_HI:`SETUP_PAIR_LO] == `PAIR_BIP) begin
                        state <= ST_EXPECT_BIP;
                    end
                end
                ST_EXPECT_UNI, ST_EXPECT_BIP: begin
                    if (byte_event || cs_s2) begin
                        state <= ST_COMMAND;
                    end
                end
                default: begin
                    state <= ST_COMMAND;
                end
            endcase
        end
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            setup_cfg <= `SETUP_RESET;
        end else if (full_reset) begin
            setup_cfg <= `SETUP_RESET;
        end else if (byte_event && state == ST_COMMAND && is_setup) begin
            setup_cfg.clock_mode <= rx_byte[`SETUP_CLK_HI:`SETUP_CLK_LO];
            setup_cfg.reference_mode <= rx_byte[`SETUP_REF_HI:`SETUP_REF_LO];
            setup_cfg.pairing_select <= rx_byte[`SETUP_PAIR_HI:`SETUP_PAIR_LO];
        end
    end

    // pair registers change only through the byte after a pairing setup byte, or a full reset command
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            unipolar_pair_select <= `BYTE_RESET;
            bipolar_pair_select <= `BYTE_RESET;
        end else if (full_reset) begin
            unipolar_pair_select <= `BYTE_RESET;
            bipolar_pair_select <= `BYTE_RESET;
        end else if (byte_event && state == ST_EXPECT_UNI) begin
            unipolar_pair_select <= rx_byte;
        end else if (byte_event && state == ST_EXPECT_BIP) begin
            bipolar_pair_select <= rx_byte;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            averaging_cfg <= `AVG_RESET;
        end else if (full_reset) begin
            averaging_cfg <= `AVG_RESET;
        end else if (byte_event && state == ST_COMMAND && is_avg) begin
            averaging_cfg.averaging_enable <= rx_byte[`AVG_EN_BIT];
            averaging_cfg.average_count <= rx_byte[`AVG_CNT_HI:`AVG_CNT_LO];
            averaging_cfg.repeat_count <= rx_byte[`AVG_REP_HI:`AVG_REP_LO];
        end
    end

    // ----------------------------------------
    // decoded modes
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            convert_start_pin_active <= 1'b0;
            top_channel_shared_pin_analog <= 1'b1;
            sclk_conversion_clock <= 1'b0;
        end else begin
            convert_start_pin_active <= !setup_cfg.clock_mode[1];
            top_channel_shared_pin_analog <= setup_cfg.clock_mode[1];
            sclk_conversion_clock <= setup_cfg.clock_mode == `CLK_MODE_11;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            second_channel_shared_pin_analog <= 1'b1;
            reference_internal <= 1'b1;
            reference_always_on <= 1'b0;
            reference_wake_needed <= 1'b1;
        end else begin
            second_channel_shared_pin_analog <= setup_cfg.reference_mode != `REF_EXT_DIFF;
            reference_internal <= !setup_cfg.reference_mode[0];
            reference_always_on <= setup_cfg.reference_mode == `REF_INT_ON;
            reference_wake_needed <= setup_cfg.reference_mode == `REF_INT_AUTO;
        end
    end

    // averaging disabled gives one conversion; the count is 4 shifted by its field, repeats are 4 times one more than the field
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conversions_per_result <= 6'h01;
            repeat_results <= 5'h04;
        end else begin
            if (averaging_cfg.averaging_enable) begin
                conversions_per_result <= 6'h04 << averaging_cfg.average_count;
            end else begin
                conversions_per_result <= 6'h01;
            end
            repeat_results <= {1'b0, averaging_cfg.repeat_count, 2'h0} + 5'h04;
        end
    end

    // ----------------------------------------
    // conversion requests and FIFO clear
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_cmd <= 7'h00;
            conv_cmd_valid <= 1'b0;
        end else begin
            conv_cmd_valid <= byte_event && state == ST_COMMAND && is_conv;
            if (byte_event && state == ST_COMMAND && is_conv) begin
                conv_cmd.channel <= rx_byte[`CONV_CH_HI:`CONV_CH_LO];
                conv_cmd.scan_mode <= rx_byte[`CONV_SCAN_HI:`CONV_SCAN_LO];
                conv_cmd.temp_request <= rx_byte[`CONV_TEMP_BIT];
            end
        end
    end

    // the pin starts conversions only while it is the convert-start input
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conversion_start <= 1'b0;
        end else if (setup_cfg.clock_mode[1]) begin
            conversion_start <= byte_event && state == ST_COMMAND && is_conv;
        end else begin
            conversion_start <= pin_rise;
        end
    end

    // both reset flavours empty the FIFO; only bit 3 clear touches the registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fifo_clear <= 1'b0;
        end else begin
            fifo_clear <= byte_event && state == ST_COMMAND && is_reset;
        end
    end

    // ----------------------------------------
    // result formatting
    // ----------------------------------------
    logic [7:0] ch_mask;
    logic ch_bipolar;
    logic [11:0] temp_diff;

    assign ch_mask = 8'h01 << pair_bit(conv_channel);
    assign ch_bipolar = |(ch_mask & bipolar_pair_select & ~unipolar_pair_select);
    assign temp_diff = temp_high_code - temp_low_code;
    // the sensor codes already step an eighth of a degree per LSB, so the difference
    // needs no scaling; only the fixed offset is taken off below

    // results are taken only between frames so the link never sees a torn word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_word <= 16'h0000;
            result_taken <= 1'b0;
        end else begin
            result_taken <= cs_s2 && (temp_valid || conv_valid);
            if (cs_s2 && temp_valid) begin
                result_word <= {4'h0, temp_diff - `TEMP_KELVIN_OFFSET};
            end else if (cs_s2 && conv_valid && ch_bipolar) begin
                result_word <= {4'h0, conv_code ^ `BIPOLAR_FLIP};
            end else if (cs_s2 && conv_valid) begin
                result_word <= {4'h0, conv_code};
            end
        end
    end
endmodule
`default_nettype wire

// ---- design/adc_cfg_consts.svh ----
// named constants for the serial configuration decoder
`ifndef ADC_CFG_CONSTS_SVH
`define ADC_CFG_CONSTS_SVH
// command byte class patterns, matched on the leading bits
`define CMD_CONV_BIT 7
`define CMD_SETUP_BIT 6
`define CMD_AVG_BIT 5
`define CMD_RESET_BIT 4
`define RESET_FIFO_ONLY_BIT 3
// setup byte fields
`define SETUP_CLK_HI 5
`define SETUP_CLK_LO 4
`define SETUP_REF_HI 3
`define SETUP_REF_LO 2
`define SETUP_PAIR_HI 1
`define SETUP_PAIR_LO 0
// averaging byte fields
`define AVG_EN_BIT 4
`define AVG_CNT_HI 3
`define AVG_CNT_LO 2
`define AVG_REP_HI 1
`define AVG_REP_LO 0
// conversion byte fields
`define CONV_CH_HI 6
`define CONV_CH_LO 3
`define CONV_SCAN_HI 2
`define CONV_SCAN_LO 1
`define CONV_TEMP_BIT 0
// mode codes
`define CLK_MODE_00 2'h0
`define CLK_MODE_01 2'h1
`define CLK_MODE_10 2'h2
`define CLK_MODE_11 2'h3
`define REF_INT_AUTO 2'h0
`define REF_EXT_SINGLE 2'h1
`define REF_INT_ON 2'h2
`define REF_EXT_DIFF 2'h3
`define PAIR_UNI 2'h2
`define PAIR_BIP 2'h3
// reset values
`define SETUP_RESET 6'h20
`define BYTE_RESET 8'h00
`define AVG_RESET 5'h00
// result word layout, last bit of a received byte and top pair bit
`define RESULT_MSB_CODE 4'hF
`define BIPOLAR_FLIP 12'h800
`define TEMP_KELVIN_OFFSET 12'h888
`define BIT_LAST 3'h7
`define PAIR_TOP 3'h7
`endif

// ---- design/adc_cfg_pkg.sv ----
// types shared by the serial configuration decoder
package adc_cfg_pkg;
    typedef struct packed {
        logic [1:0] clock_mode;
        logic [1:0] reference_mode;
        logic [1:0] pairing_select;
    } setup_t;
    typedef struct packed {
        logic averaging_enable;
        logic [1:0] average_count;
        logic [1:0] repeat_count;
    } avg_t;
    typedef struct packed {
        logic [3:0] channel;
        logic [1:0] scan_mode;
        logic temp_request;
    } conv_cmd_t;
    typedef enum logic [2:0] {
        ST_COMMAND = 3'h1,
        ST_EXPECT_UNI = 3'h2,
        ST_EXPECT_BIP = 3'h4
    } decode_state_t;
endpackage

// ---- test/adc_cfg_asserts.sv ----
// assertion checker for the serial configuration decoder
`timescale 1ns/1ps
`include "adc_cfg_consts.svh"
`default_nettype none
module adc_cfg_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration
    input wire adc_cfg_pkg::setup_t setup_cfg,
    input wire logic [7:0] unipolar_pair_select,
    input wire logic [7:0] bipolar_pair_select,
    input wire adc_cfg_pkg::avg_t averaging_cfg,
    input wire logic convert_start_pin_active,
    input wire logic top_channel_shared_pin_analog,
    input wire logic second_channel_shared_pin_analog,
    input wire logic reference_wake_needed,
    input wire logic sclk_conversion_clock,
    input wire logic [5:0] conversions_per_result,
    input wire logic [4:0] repeat_results,
    // starts and results
    input wire logic convert_start_pin,
    input wire logic conversion_start,
    input wire logic conv_valid,
    input wire logic [11:0] conv_code,
    input wire logic [3:0] conv_channel,
    input wire logic temp_valid,
    input wire logic [11:0] temp_high_code,
    input wire logic [11:0] temp_low_code,
    input wire logic [15:0] result_word,
    input wire logic result_taken
);
    import adc_cfg_pkg::*;
    // a pair counts as bipolar only when it is not also marked unipolar
    logic [2:0] pair_bit;
    logic bip_pair;
    assign pair_bit = `PAIR_TOP - conv_channel[3:1];
    assign bip_pair = bipolar_pair_select[pair_bit] & ~unipolar_pair_select[pair_bit];
    // sampled helpers, so that the history functions only ever see plain signals
    logic conv_only;
    logic [11:0] temp_exp;
    assign conv_only = conv_valid && !temp_valid;
    assign temp_exp = temp_high_code - temp_low_code - `TEMP_KELVIN_OFFSET;
    // derived outputs lag the registers by one clock
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    pin_role_a: assert property (convert_start_pin_active == !$past(setup_cfg.clock_mode[1]))
        else $error("convert pin role wrong");
    top_pin_a: assert property (top_channel_shared_pin_analog == $past(setup_cfg.clock_mode[1]))
        else $error("top shared pin role wrong");
    ref_pin_a: assert property (second_channel_shared_pin_analog == ($past(setup_cfg.reference_mode) != 2'h3))
        else $error("second shared pin role wrong");
    ref_wake_a: assert property (reference_wake_needed == ($past(setup_cfg.reference_mode) == 2'h0))
        else $error("wake flag wrong");
    sclk_conv_a: assert property (sclk_conversion_clock == ($past(setup_cfg.clock_mode) == 2'h3))
        else $error("serial conversion clock flag wrong");
    avg_count_a: assert property (conversions_per_result == ($past(averaging_cfg.averaging_enable) ?
        6'h4 << $past(averaging_cfg.average_count) : 6'h1)) else $error("conversions per result wrong");
    repeat_count_a: assert property (repeat_results == {$past(averaging_cfg.repeat_count) + 3'h1, 2'h0})
        else $error("repeat count wrong");
    pin_start_a: assert property ($rose(convert_start_pin) && !setup_cfg.clock_mode[1] |-> ##[2:6] conversion_start)
        else $error("pin did not start a conversion");
    lead_zero_a: assert property (result_taken |-> result_word[15:12] == 4'h0)
        else $error("leading bits not zero");
    code_fmt_a: assert property (result_taken && $past(conv_only) |->
        result_word[11:0] == ($past(conv_code) ^ ($past(bip_pair) ? `BIPOLAR_FLIP : 12'h0)))
        else $error("conversion result format wrong");
    temp_fmt_a: assert property (result_taken && $past(temp_valid) |->
        result_word[11:0] == $past(temp_exp))
        else $error("temperature result wrong");
endmodule
bind adc_serial_config_decoder adc_cfg_asserts adc_cfg_asserts_i (.clk, .rst_n, .setup_cfg,
    .unipolar_pair_select, .bipolar_pair_select, .averaging_cfg, .convert_start_pin_active,
    .top_channel_shared_pin_analog, .second_channel_shared_pin_analog, .reference_wake_needed,
    .sclk_conversion_clock, .conversions_per_result, .repeat_results, .convert_start_pin, .conversion_start,
    .conv_valid, .conv_code, .conv_channel, .temp_valid, .temp_high_code, .temp_low_code, .result_word,
    .result_taken);
`default_nettype wire

// ---- test/serial_host.sv ----
// host model that frames bytes on the serial link
`timescale 1ns/1ps
`default_nettype none
module serial_host (
    // link pins toward the device
    output logic sclk,
    output logic cs_n,
    output logic din,
    // data back from the device
    input wire logic dout
);
    // serial clock stands low outside frames
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // one 16-clock frame, MSB first, with dout caught on each rising edge
    task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
        int i;
        rx = 16'h0000;
        #3.3 cs_n = 1'b0;
        for (i = 0; i < 16; i++) begin
            din = tx[15 - i]; // set up half a period ahead of the sampling edge
            #7.5 sclk = 1'b1;
            rx = {rx[14:0], dout}; // dout only moves on the falling edge
            #7.5 sclk = 1'b0;
        end
        #7.5 cs_n = 1'b1;
        din = ~din; // a released line must not keep showing the last bit
    endtask
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// self-checking bench for the serial configuration decoder
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_consts.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %s exp %h got %h", nm, (e), (g)); end end
module testbench;
    import adc_cfg_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sclk, cs_n, din, dout, conv_cmd_valid, conversion_start, fifo_clear, result_taken;
    logic convert_start_pin_active, top_channel_shared_pin_analog, second_channel_shared_pin_analog;
    logic reference_internal, reference_always_on, reference_wake_needed, sclk_conversion_clock;
    logic convert_start_pin = 1'b0;
    logic conv_valid = 1'b0;
    logic temp_valid = 1'b0;
    logic [11:0] conv_code = 12'h000;
    logic [3:0] conv_channel = 4'h0;
    logic [11:0] temp_high_code = 12'h000;
    logic [11:0] temp_low_code = 12'h000;
    logic [7:0] unipolar_pair_select, bipolar_pair_select;
    logic [5:0] conversions_per_result;
    logic [4:0] repeat_results;
    logic [15:0] result_word, rx;
    setup_t setup_cfg;
    avg_t averaging_cfg;
    conv_cmd_t conv_cmd;
    int n_fail = 0;
    int checked = 0;
    int n_start = 0;
    int n_clear = 0;
    int n_cmd = 0;
    int m;
    adc_serial_config_decoder adc_serial_config_decoder_i (.clk, .rst_n, .sclk, .cs_n, .din, .dout,
        .convert_start_pin, .setup_cfg, .unipolar_pair_select, .bipolar_pair_select, .averaging_cfg,
        .convert_start_pin_active, .top_channel_shared_pin_analog, .second_channel_shared_pin_analog,
        .reference_internal, .reference_always_on, .reference_wake_needed, .sclk_conversion_clock,
        .conversions_per_result, .repeat_results, .conv_cmd, .conv_cmd_valid, .conversion_start, .fifo_clear,
        .conv_valid, .conv_code, .conv_channel, .temp_valid, .temp_high_code, .temp_low_code, .result_word,
        .result_taken);
    serial_host serial_host_i (.sclk, .cs_n, .din, .dout);
    // clock and one-cycle pulse counters
    always #2 clk = ~clk;
    always @(posedge clk) begin
        if (conversion_start === 1'b1) n_start++;
        if (fifo_clear === 1'b1) n_clear++;
        if (conv_cmd_valid === 1'b1) n_cmd++;
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // a frame, then room for the crossing and the derived outputs to settle
    task automatic send(input logic [15:0] tx);
        serial_host_i.frame(tx, rx);
        repeat (8) @(posedge clk);
        #1;
    endtask
    // hand one raw result over while the link is idle, then wait for it to be taken
    task automatic put_result(input logic cv, input logic [11:0] code, input logic [3:0] ch, input logic [11:0] e);
        int k;
        @(posedge clk);
        // a temperature result always arrives beside a conversion, so its priority is tested
        #1 {conv_valid, temp_valid, conv_code, conv_channel} = {1'b1, ~cv, code, ch};
        @(posedge clk);
        #1 {conv_valid, temp_valid} = 2'b00;
        for (k = 0; k < 4 && result_taken !== 1'b1; k++) @(posedge clk);
        if (result_taken !== 1'b1) begin
            n_fail++;
            close_out;
        end
        `CHK("result_word", {4'h0, e}, result_word)
    endtask
    // pin pulse held long enough for the two-stage synchroniser
    task automatic pin_pulse;
        @(posedge clk);
        #1 convert_start_pin = 1'b1;
        repeat (10) @(posedge clk);
        #1 convert_start_pin = 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask
    // --------------------------------
    // main sequence
    // --------------------------------
    initial begin
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        `CHK("setup", 6'h20, setup_cfg)
        `CHK("regs", 21'h0, {unipolar_pair_select, bipolar_pair_select, averaging_cfg})
        for (m = 0; m < 4; m++) begin
            send({2'b01, m[1:0], m[1:0], 10'h000});
            `CHK("setup", {m[1:0], m[1:0], 2'b00}, setup_cfg)
            `CHK("ref_on", (m == 2), reference_always_on)
            `CHK("ref_int", ~m[0], reference_internal)
            `CHK("pin_act", ~m[1], convert_start_pin_active)
        end
        send(16'h7AA5);
        send(16'h7F3C);
        `CHK("uni", 8'hA5, unipolar_pair_select)
        `CHK("bip", 8'h3C, bipolar_pair_select)
        // pairing 01 makes the second byte a fresh averaging command
        send(16'h453B);
        `CHK("pairs", 16'hA53C, {unipolar_pair_select, bipolar_pair_select})
        `CHK("avg", 5'h1B, averaging_cfg)
        for (m = 0; m < 4; m++) begin
            send({4'h3, m[1:0], m[1:0], 8'h00});
            `CHK("per_result", 6'(4 << m), conversions_per_result)
            `CHK("repeats", 5'(4 * (m + 1)), repeat_results)
        end
        send(16'h2F00);
        `CHK("per_result", 6'h01, conversions_per_result)
        send(16'h1F00);
        `CHK("clears", 1, n_clear)
        `CHK("keep", 11'h0AF, {setup_cfg, averaging_cfg})
        // results: both-marked pair, bipolar pair, temperature winning over a conversion
        put_result(1'b1, 12'h9AB, 4'h4, 12'h9AB);
        put_result(1'b1, 12'h9AB, 4'h6, 12'h1AB);
        temp_high_code = 12'hF00;
        temp_low_code = 12'h100;
        put_result(1'b0, 12'h123, 4'h0, 12'hE00 - `TEMP_KELVIN_OFFSET);
        send(16'h0000);
        `CHK("dout", {4'h0, 12'hE00 - `TEMP_KELVIN_OFFSET}, rx)
        pin_pulse;
        `CHK("pin_start", 1, n_start)
        send(16'h6000);
        pin_pulse;
        `CHK("pin_ignored", 1, n_start)
        send(16'hAD00);
        `CHK("conv_cmd", 7'h2D, conv_cmd)
        `CHK("cmd_valid", 1, n_cmd)
        `CHK("byte_start", 2, n_start)
        send(16'h1700);
        `CHK("setup", 6'h20, setup_cfg)
        `CHK("regs", 21'h0, {unipolar_pair_select, bipolar_pair_select, averaging_cfg})
        `CHK("clears", 2, n_clear)
        close_out;
    end
    // cut a hang short
    initial begin
        #300000;
        n_fail++;
        close_out;
    end
endmodule
`default_nettype wire
